/* caf_defs.vh */
// constants for the receive acceptance filter and interrupt-source block
`ifndef CAF_DEFS_VH
`define CAF_DEFS_VH

// register byte addresses
`define CAF_ADDR_CTRL0      8'h00
`define CAF_ADDR_CTRL1      8'h04
`define CAF_ADDR_BTIME0     8'h08
`define CAF_ADDR_BTIME1     8'h0C
`define CAF_ADDR_RXFLG      8'h10
`define CAF_ADDR_RXIEN      8'h14
`define CAF_ADDR_TXFLG      8'h18
`define CAF_ADDR_TXIEN      8'h1C
`define CAF_ADDR_FCTRL      8'h20
`define CAF_ADDR_ERRCNT     8'h24
// pattern bytes 0-7 at 0x40-0x5C, don't-care bytes 0-7 at 0x60-0x7C
`define CAF_PAGE_PAT        3'h2
`define CAF_PAGE_MASK       3'h3

// module_ctrl0 fields
`define CAF_CTRL0_LOCK      0
`define CAF_CTRL0_SLPRQ     1
`define CAF_CTRL0_SLEEP_ACK     2

// rx_flag_reg / rx enable fields
`define CAF_RF_RXF          0
`define CAF_RF_OVR          1
`define CAF_RF_BOFF         2
`define CAF_RF_TPAS         3
`define CAF_RF_RPAS         4
`define CAF_RF_TWRN         5
`define CAF_RF_RWRN         6
`define CAF_RF_WUP          7

// filter_ctrl_reg fields
`define CAF_FC_HIT_LSB      0
`define CAF_FC_MODE_LSB     4

// filter modes
`define CAF_MODE_TWO32      2'h0
`define CAF_MODE_FOUR16     2'h1
`define CAF_MODE_EIGHT8     2'h2
`define CAF_MODE_CLOSED     2'h3

// reset values
`define CAF_RST_CTRL0       1'h1
`define CAF_RST_BYTE        8'h00
`define CAF_RST_TXE         3'h7
`define CAF_RST_MODE        2'h0
`define CAF_RST_BANK        64'h0000000000000000

// error counter limits
`define CAF_WARN_LIMIT      9'h060
`define CAF_PASSIVE_LIMIT   9'h07F
`define CAF_BUSOFF_LIMIT    9'h0FF

`endif

/* caf_match.v */
// one maskable identifier comparator of configurable width
`timescale 1ns/1ps
module caf_match #(
  parameter W = 8
) (
  // compared bits
  input  wire [W-1:0] id_bits,
  input  wire [W-1:0] pattern,
  input  wire [W-1:0] dont_care,
  // result
  output wire         hit
);

  // a set don't-care bit forces that position to agree
  assign hit = &((~(id_bits ^ pattern)) | dont_care); // [RULE1]

endmodule // caf_match

/* caf_filter_top.v */
// acceptance filter, interrupt sources and protection logic of the can controller
//
// Function
// [RULE1] compare id to pattern, skip don't-care bits
// [RULE2] acceptance sets rx full and hit index
// [RULE3] lowest matching filter wins the hit index
// [RULE4] two 32-bit filters give hits 0-1
// [RULE5] four 16-bit filters give hits 0-3
// [RULE6] eight 8-bit filters give hits 0-7
// [RULE7] closed mode never fills front buffer
// [RULE8] accepted message raises receive request if enabled
// [RULE9] eleven sources, four requests, own enables
// [RULE10] transmit request from any empty flag enabled
// [RULE11] rx full set right after end of frame
// [RULE12] bus activity during sleep sets wake-up flag
// [RULE13] error counter at 96 sets warning flag
// [RULE14] counter above 127 sets error-passive flag
// [RULE15] transmit counter above 255 sets bus-off
// [RULE16] flags pend until software writes one
// [RULE17] clear ignored while setting condition holds
// [RULE18] software must not clear by read-modify-write
// [RULE19] error counters cannot be written
// [RULE20] config registers writable only under soft reset
// [RULE21] tx pin recessive in low-power modes
// [RULE22] third accepted message dropped, overrun flagged
// [RULE23] copy back to front only while rx full clear
// [RULE24] wake-up request needs sleep ack and enable
// [RULE25] writing zero keeps flags, reads show state
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`include "caf_defs.vh"
module caf_filter_top (
  // clock and reset
  input  wire        ref_clk,
  input  wire        rst,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // protocol engine, receive side
  input  wire        rx_frame_done,
  input  wire [31:0] rx_id_bytes,
  output reg         rx_front_load_r,
  // protocol engine, transmit side
  input  wire [2:0]  tx_buf_done,
  input  wire        can_tx_core,
  output reg  [2:0]  tx_empty_r,
  // error counters and mode status
  input  wire [8:0]  rx_err_cnt,
  input  wire [8:0]  tx_err_cnt,
  input  wire        sleep_ack,
  input  wire        power_down,
  // configuration to the engine
  output reg         soft_reset_lock_r,
  output reg         sleep_req_r,
  output reg  [7:0]  module_ctrl1_r,
  output reg  [7:0]  bit_timing0_r,
  output reg  [7:0]  bit_timing1_r,
  // can pins
  input  wire        can_rx_pin,
  output reg         can_tx_pin_r,
  // interrupt requests
  output reg         irq_wakeup_r,
  output reg         irq_error_r,
  output reg         irq_rx_r,
  output reg         irq_tx_r
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  reg  [7:0]  rx_flag_r;
  reg  [7:0]  rx_irq_en_r;
  reg  [2:0]  tx_irq_en_r;
  reg  [1:0]  filter_mode_r;
  reg  [2:0]  filter_hit_index_r;
  reg  [63:0] id_pattern_r;
  reg  [63:0] id_dontcare_r;
  reg         bg_full_r;
  reg  [2:0]  bg_hit_r;
  reg         rx_meta_r;
  reg         rx_sync_r;
  reg         rx_prev_r;

  reg  [7:0]  rx_flag_nxt;
  reg  [2:0]  tx_empty_nxt;
  reg  [31:0] rd_data;
  reg         addr_ok;
  reg  [7:0]  hit_sel;
  reg         hit_any;
  reg  [2:0]  hit_idx;
  integer     i;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  wire        setup_done = psel & penable & ~pready;
  wire        bus_wr     = psel & penable & pready & pwrite;
  wire [2:0]  page       = paddr[7:5];
  wire [5:0]  byte_base  = {~paddr[4:2], 3'b000};
  wire        cfg_open   = soft_reset_lock_r;
  wire        in_bank    = (page == `CAF_PAGE_PAT) || (page == `CAF_PAGE_MASK);
  wire        bank_wr    = bus_wr & in_bank & (paddr[1:0] == 2'b00);
  wire [7:0]  rx_w1c     = (bus_wr && paddr == `CAF_ADDR_RXFLG) ? pwdata[7:0] : 8'h00;
  wire [2:0]  tx_w1c     = (bus_wr && paddr == `CAF_ADDR_TXFLG) ? pwdata[2:0] : 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // comparators

  wire [1:0]  hit32;
  wire [3:0]  hit16;
  wire [7:0]  hit8;

  genvar g;
  generate
    // full identifier with rtr/ide/srr: bank 0 and bank 1
    for (g = 0; g < 2; g = g + 1) begin : g_m32
      caf_match #(.W(32)) u_m (
        .id_bits   (rx_id_bytes),
        .pattern   (id_pattern_r[63-32*g -: 32]),
        .dont_care (id_dontcare_r[63-32*g -: 32]),
        .hit       (hit32[g])
      ); // [RULE4]
    end
    // upper two identifier bytes per 16-bit half bank
    for (g = 0; g < 4; g = g + 1) begin : g_m16
      caf_match #(.W(16)) u_m (
        .id_bits   (rx_id_bytes[31:16]),
        .pattern   (id_pattern_r[63-16*g -: 16]),
        .dont_care (id_dontcare_r[63-16*g -: 16]),
        .hit       (hit16[g])
      ); // [RULE5]
    end
    // first identifier byte per filter byte
    for (g = 0; g < 8; g = g + 1) begin : g_m8
      caf_match #(.W(8)) u_m (
        .id_bits   (rx_id_bytes[31:24]),
        .pattern   (id_pattern_r[63-8*g -: 8]),
        .dont_care (id_dontcare_r[63-8*g -: 8]),
        .hit       (hit8[g])
      ); // [RULE6]
    end
  endgenerate

  // mode select and lowest-index priority
  always @* begin
    hit_any = 1'b0;
    hit_idx = 3'h0;
    case (filter_mode_r)
      `CAF_MODE_TWO32:  hit_sel = {6'h00, hit32}; // [RULE4]
      `CAF_MODE_FOUR16: hit_sel = {4'h0, hit16}; // [RULE5]
      `CAF_MODE_EIGHT8: hit_sel = hit8; // [RULE6]
      default:          hit_sel = 8'h00; // [RULE7]
    endcase
    // scan downward so the last hit kept is the lowest one
    for (i = 7; i >= 0; i = i - 1) begin
      if (hit_sel[i]) begin
        hit_any = 1'b1;
        hit_idx = i[2:0]; // [RULE3]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive buffer occupancy

  wire accept   = rx_frame_done & hit_any; // [RULE1]
  // copy waits for a clear rx full and is held off during sleep
  wire copy_now = bg_full_r & ~rx_flag_r[`CAF_RF_RXF] & ~sleep_ack; // [RULE23]
  // both buffers hold messages when the back one cannot drain this cycle
  wire overrun  = accept & bg_full_r & ~copy_now; // [RULE22]

  always @(posedge ref_clk) begin
    if (rst) begin
      bg_full_r          <= 1'b0;
      bg_hit_r           <= 3'h0;
      filter_hit_index_r <= 3'h0;
      rx_front_load_r    <= 1'b0;
    end else begin
      rx_front_load_r <= copy_now;
      if (copy_now) begin
        filter_hit_index_r <= bg_hit_r; // [RULE2]
      end
      if (accept && !overrun) begin
        bg_full_r <= 1'b1;
        bg_hit_r  <= hit_idx;
      end else if (copy_now) begin
        bg_full_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags

  // bus activity is a dominant edge on the synchronised receive pin
  wire bus_activity = rx_prev_r & ~rx_sync_r;

  always @* begin
    // set wins over a write-one clear in the same cycle
    rx_flag_nxt = rx_flag_r & ~rx_w1c; // [RULE16] [RULE25]
    if (copy_now) begin
      rx_flag_nxt[`CAF_RF_RXF] = 1'b1; // [RULE2] [RULE11]
    end
    if (overrun) begin
      rx_flag_nxt[`CAF_RF_OVR] = 1'b1; // [RULE22]
    end
    if (sleep_ack && bus_activity) begin
      rx_flag_nxt[`CAF_RF_WUP] = 1'b1; // [RULE12]
    end
    // level conditions re-assert every cycle, so a clear cannot stick
    if (rx_err_cnt >= `CAF_WARN_LIMIT) begin
      rx_flag_nxt[`CAF_RF_RWRN] = 1'b1; // [RULE13] [RULE17]
    end
    if (tx_err_cnt >= `CAF_WARN_LIMIT) begin
      rx_flag_nxt[`CAF_RF_TWRN] = 1'b1; // [RULE13] [RULE17]
    end
    if (rx_err_cnt > `CAF_PASSIVE_LIMIT) begin
      rx_flag_nxt[`CAF_RF_RPAS] = 1'b1; // [RULE14] [RULE17]
    end
    if (tx_err_cnt > `CAF_PASSIVE_LIMIT) begin
      rx_flag_nxt[`CAF_RF_TPAS] = 1'b1; // [RULE14] [RULE17]
    end
    if (tx_err_cnt > `CAF_BUSOFF_LIMIT) begin
      rx_flag_nxt[`CAF_RF_BOFF] = 1'b1; // [RULE15] [RULE17]
    end
    tx_empty_nxt = tx_buf_done | (tx_empty_r & ~tx_w1c); // [RULE16] [RULE25]
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      rx_flag_r  <= 8'h00;
      tx_empty_r <= `CAF_RST_TXE;
    end else begin
      rx_flag_r  <= rx_flag_nxt;
      tx_empty_r <= tx_empty_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  always @(posedge ref_clk) begin
    if (rst) begin
      soft_reset_lock_r <= `CAF_RST_CTRL0;
      sleep_req_r       <= 1'b0;
      module_ctrl1_r    <= `CAF_RST_BYTE;
      bit_timing0_r     <= `CAF_RST_BYTE;
      bit_timing1_r     <= `CAF_RST_BYTE;
      filter_mode_r     <= `CAF_RST_MODE;
      id_pattern_r      <= `CAF_RST_BANK;
      id_dontcare_r     <= `CAF_RST_BANK;
      rx_irq_en_r       <= 8'h00;
      tx_irq_en_r       <= 3'h0;
    end else if (bus_wr) begin
      case (paddr)
        `CAF_ADDR_CTRL0: begin
          soft_reset_lock_r <= pwdata[`CAF_CTRL0_LOCK];
          sleep_req_r       <= pwdata[`CAF_CTRL0_SLPRQ];
        end
        `CAF_ADDR_CTRL1: begin
          if (cfg_open) module_ctrl1_r <= pwdata[7:0]; // [RULE20]
        end
        `CAF_ADDR_BTIME0: begin
          if (cfg_open) bit_timing0_r <= pwdata[7:0]; // [RULE20]
        end
        `CAF_ADDR_BTIME1: begin
          if (cfg_open) bit_timing1_r <= pwdata[7:0]; // [RULE20]
        end
        `CAF_ADDR_FCTRL: begin
          if (cfg_open) filter_mode_r <= pwdata[`CAF_FC_MODE_LSB +: 2]; // [RULE20]
        end
        `CAF_ADDR_RXIEN: begin
          rx_irq_en_r <= pwdata[7:0];
        end
        `CAF_ADDR_TXIEN: begin
          tx_irq_en_r <= pwdata[2:0];
        end
        default: begin
          if (bank_wr && cfg_open && page == `CAF_PAGE_PAT) begin
            id_pattern_r[byte_base +: 8] <= pwdata[7:0]; // [RULE20]
          end
          if (bank_wr && cfg_open && page == `CAF_PAGE_MASK) begin
            id_dontcare_r[byte_base +: 8] <= pwdata[7:0]; // [RULE20]
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux

  always @* begin
    rd_data = 32'h00000000;
    addr_ok = 1'b1;
    case (paddr)
      `CAF_ADDR_CTRL0: begin
        rd_data[`CAF_CTRL0_LOCK]  = soft_reset_lock_r;
        rd_data[`CAF_CTRL0_SLPRQ] = sleep_req_r;
        rd_data[`CAF_CTRL0_SLEEP_ACK] = sleep_ack;
      end
      `CAF_ADDR_CTRL1:  rd_data[7:0] = module_ctrl1_r;
      `CAF_ADDR_BTIME0: rd_data[7:0] = bit_timing0_r;
      `CAF_ADDR_BTIME1: rd_data[7:0] = bit_timing1_r;
      `CAF_ADDR_RXFLG:  rd_data[7:0] = rx_flag_r; // [RULE25]
      `CAF_ADDR_RXIEN:  rd_data[7:0] = rx_irq_en_r;
      `CAF_ADDR_TXFLG:  rd_data[2:0] = tx_empty_r; // [RULE25]
      `CAF_ADDR_TXIEN:  rd_data[2:0] = tx_irq_en_r;
      `CAF_ADDR_FCTRL: begin
        rd_data[`CAF_FC_MODE_LSB +: 2] = filter_mode_r;
        rd_data[`CAF_FC_HIT_LSB +: 3]  = filter_hit_index_r; // [RULE2]
      end
      // counters are visible but have no write path at all
      `CAF_ADDR_ERRCNT: rd_data[24:0] = {tx_err_cnt, 7'h00, rx_err_cnt}; // [RULE19]
      default: begin
        if (in_bank && paddr[1:0] == 2'b00) begin
          if (page == `CAF_PAGE_PAT) begin
            rd_data[7:0] = id_pattern_r[byte_base +: 8];
          end else begin
            rd_data[7:0] = id_dontcare_r[byte_base +: 8];
          end
        end else begin
          addr_ok = 1'b0;
        end
      end
    endcase
  end

  // one wait state: the answer is registered at the first access edge
  always @(posedge ref_clk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup_done;
      pslverr <= setup_done & ~addr_ok;
      if (setup_done && !pwrite) begin
        prdata <= rd_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser and transmit pin

  always @(posedge ref_clk) begin
    if (rst) begin
      rx_meta_r    <= 1'b1;
      rx_sync_r    <= 1'b1;
      rx_prev_r    <= 1'b1;
      can_tx_pin_r <= 1'b1;
    end else begin
      rx_meta_r <= can_rx_pin;
      rx_sync_r <= rx_meta_r;
      rx_prev_r <= rx_sync_r;
      // recessive is high; forced in sleep, soft reset and power down
      if (sleep_ack || soft_reset_lock_r || power_down) begin
        can_tx_pin_r <= 1'b1; // [RULE21]
      end else begin
        can_tx_pin_r <= can_tx_core;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt requests

  always @(posedge ref_clk) begin
    if (rst) begin
      irq_wakeup_r <= 1'b0;
      irq_error_r  <= 1'b0;
      irq_rx_r     <= 1'b0;
      irq_tx_r     <= 1'b0;
    end else begin
      // requests follow the flags, so they pend until cleared, except wake-up, which also drops with sleep_ack
      irq_wakeup_r <= rx_flag_r[`CAF_RF_WUP] & rx_irq_en_r[`CAF_RF_WUP]
                      & sleep_ack; // [RULE9] [RULE16] [RULE24]
      irq_error_r  <= |(rx_flag_r[6:1] & rx_irq_en_r[6:1]); // [RULE9] [RULE16] [RULE22]
      irq_rx_r     <= rx_flag_r[`CAF_RF_RXF] & rx_irq_en_r[`CAF_RF_RXF]; // [RULE8] [RULE11]
      irq_tx_r     <= |(tx_empty_r & tx_irq_en_r); // [RULE9] [RULE10]
    end
  end

endmodule // caf_filter_top

/* caf_bus_node.sv */
// far-side model: other nodes on the can bus as the engine reports them
`timescale 1ns/1ps
module caf_bus_node (
  // clock
  input  wire        ref_clk,
  // pin and engine side
  output reg         can_rx_pin,
  output reg         rx_frame_done,
  output reg  [31:0] rx_id_bytes
);
  initial begin
    can_rx_pin = 1'b1;
    rx_frame_done = 1'b0;
    rx_id_bytes = 32'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // dominant activity for len cycles, then end of frame for one cycle
  task send(input [31:0] id, input integer len, input bit done);
    begin
      @(posedge ref_clk);
      can_rx_pin <= 1'b0;
      repeat (len) @(posedge ref_clk);
      can_rx_pin <= 1'b1;
      rx_frame_done <= done;
      rx_id_bytes <= id;
      @(posedge ref_clk);
      rx_frame_done <= 1'b0;
      // the identifier is only valid with the pulse, so do not hold it
      rx_id_bytes <= ~id;
    end
  endtask
endmodule // caf_bus_node

/* caf_filter_checker.sv */
// port-level assertions for the acceptance filter top
`timescale 1ns/1ps
module caf_filter_checker (
  // clock and reset
  input wire       ref_clk,
  input wire       rst,
  // apb
  input wire       psel,
  input wire       penable,
  input wire       pwrite,
  input wire [7:0] paddr,
  input wire       pready,
  // engine side
  input wire       rx_frame_done,
  input wire       rx_front_load_r,
  input wire [2:0] tx_buf_done,
  input wire [2:0] tx_empty_r,
  input wire       can_tx_core,
  input wire       sleep_ack,
  input wire       power_down,
  input wire       soft_reset_lock_r,
  // pins and requests
  input wire       can_tx_pin_r,
  input wire       irq_wakeup_r,
  input wire       irq_tx_r
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire wr_done = psel && penable && pready && pwrite;
  wire lowp    = sleep_ack || soft_reset_lock_r || power_down;
  wire cause   = rx_frame_done || wr_done || sleep_ack;

  ////////////////////////////////////////////////////////////////////////
  a_tx_recessive: assert property (lowp |=> can_tx_pin_r)
    else $error("tx pin not recessive in low power");
  a_tx_follows: assert property (!lowp |=> can_tx_pin_r == $past(can_tx_core))
    else $error("tx pin does not follow the engine");
  a_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("apb answer not after one wait state");
  a_load_cause: assert property (rx_front_load_r |->
      $past(cause) || $past(cause, 2) || $past(cause, 3))
    else $error("front buffer load without a cause");
  a_wake_gate: assert property (irq_wakeup_r |-> $past(sleep_ack))
    else $error("wake request without sleep ack");
  a_tx_irq_src: assert property (irq_tx_r |-> $past(tx_empty_r) != 3'h0)
    else $error("tx request with no empty buffer");
  a_txe_set: assert property (|tx_buf_done |=>
      (tx_empty_r & $past(tx_buf_done)) == $past(tx_buf_done))
    else $error("tx empty flag not set by buffer done");
  a_txe_clear: assert property (($past(tx_empty_r) & ~tx_empty_r) != 3'h0 |->
      $past(wr_done && paddr == 8'h18))
    else $error("tx empty flag fell without a write");
  a_lock_clear: assert property ($fell(soft_reset_lock_r) |->
      $past(wr_done && paddr == 8'h00))
    else $error("lock fell without a write");
  c_load: cover property (rx_front_load_r);
  c_wake: cover property (irq_wakeup_r);
  c_unlock: cover property ($fell(soft_reset_lock_r));
endmodule // caf_filter_checker

bind caf_filter_top caf_filter_checker i_chk (.ref_clk, .rst, .psel, .penable, .pwrite,
  .paddr, .pready, .rx_frame_done, .rx_front_load_r, .tx_buf_done, .tx_empty_r,
  .can_tx_core, .sleep_ack, .power_down, .soft_reset_lock_r, .can_tx_pin_r,
  .irq_wakeup_r, .irq_tx_r);

/* can_accept_filter_irq_tb.sv */
// self-checking bench for the acceptance filter and interrupt block
`timescale 1ns/1ps
`include "caf_defs.vh"
module can_accept_filter_irq_tb;
  reg         ref_clk, rst, psel, penable, pwrite, can_tx_core, sleep_ack, power_down;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata, q, id;
  reg  [2:0]  tx_buf_done;
  reg  [8:0]  rx_err_cnt, tx_err_cnt;
  reg  [7:0]  pat [0:7];
  reg  [7:0]  msk [0:7];
  reg         slv;
  wire [31:0] prdata, rx_id_bytes;
  wire        pready, pslverr, rx_frame_done, can_rx_pin;
  wire        irq_wakeup_r, irq_error_r, irq_rx_r, irq_tx_r;
  wire        sleep_req_r, can_tx_pin_r;
  wire [7:0]  module_ctrl1_r, bit_timing0_r, bit_timing1_r;
  integer     num_errors, checks, m, t, f, i, h, nf, nb;
  integer     ev [0:5] = '{95, 96, 127, 128, 255, 256};

  caf_filter_top i_dut (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rx_frame_done, .rx_id_bytes, .rx_front_load_r(), .tx_buf_done,
    .can_tx_core, .tx_empty_r(), .rx_err_cnt, .tx_err_cnt, .sleep_ack, .power_down,
    .soft_reset_lock_r(), .sleep_req_r, .module_ctrl1_r, .bit_timing0_r,
    .bit_timing1_r, .can_rx_pin, .can_tx_pin_r, .irq_wakeup_r, .irq_error_r,
    .irq_rx_r, .irq_tx_r);
  caf_bus_node i_node (.ref_clk, .can_rx_pin, .rx_frame_done, .rx_id_bytes);

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) can_tx_core <= rst ? 1'b0 : ~can_tx_core;

  ////////////////////////////////////////////////////////////////////////
  task conclude;
    begin
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask

  task chk(input string what, input [31:0] exp, input [31:0] got);
    begin
      checks = checks + 1;
      if (exp !== got) begin
        num_errors = num_errors + 1;
        $display("Error %s expected %h seen %h", what, exp, got);
      end
    end
  endtask

  task apb(input bit w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do begin
        @(posedge ref_clk);
        n = n + 1;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
        num_errors = num_errors + 1;
        conclude;
      end
    end
  endtask

  task wr(input [7:0] a, input [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rdc(input string what, input [7:0] a, input [31:0] mk, input [31:0] exp);
    begin
      apb(1'b0, a, 32'h0);
      chk(what, exp, q & mk);
    end
  endtask

  // lowest accepting filter, 8 when none accepts
  function integer hit_of(input [31:0] v);
    integer k, j, ok;
    begin
      hit_of = 8;
      for (k = nf - 1; k >= 0; k = k - 1) begin
        ok = 1;
        for (j = 0; j < nb; j = j + 1)
          if ((v[31 - 8 * j -: 8] ^ pat[k * nb + j]) & ~msk[k * nb + j]) ok = 0;
        if (ok) hit_of = k;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h213A0049));
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {tx_buf_done, rx_err_cnt, tx_err_cnt, sleep_ack, power_down} = '0;
    num_errors = 0;
    checks = 0;
    rst = 1'b1;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    rdc("ctrl0", `CAF_ADDR_CTRL0, 32'hFFFFFFFF, 32'h1);
    chk("tx pin", 32'h1, can_tx_pin_r);
    rdc("tx flags", `CAF_ADDR_TXFLG, 32'hFFFFFFFF, 32'h7);
    rdc("filter ctrl", `CAF_ADDR_FCTRL, 32'hFFFFFFFF, 32'h0);
    rdc("unmapped", 8'h30, 32'hFFFFFFFF, 32'h0);
    chk("slverr", 32'h1, slv);
    wr(`CAF_ADDR_RXIEN, 32'h7F);
    for (m = 0; m < 4; m = m + 1) begin
      nf = (m == 3) ? 0 : 2 << m;
      nb = 4 >> (m % 3);
      for (i = 0; i < 8; i = i + 1) begin
        pat[i] = 8'($urandom);
        msk[i] = (m == 2 && i == 7) ? 8'hFF : 8'($urandom & $urandom);
        wr(8'(8'h40 + 4 * i), {24'h0, pat[i]});
        wr(8'(8'h60 + 4 * i), {24'h0, msk[i]});
      end
      wr(`CAF_ADDR_FCTRL, 32'(m * 16));
      for (t = 0; t < 6; t = t + 1) begin
        id = $urandom;
        f = $urandom % (2 << (m % 3));
        for (i = 0; i < nb && t % 2; i = i + 1) id[31 - 8 * i -: 8] = pat[f * nb + i];
        h = hit_of(id);
        i_node.send(id, 1 + 4 * t, 1'b1);
        repeat (6) @(posedge ref_clk);
        chk("rx irq", 32'(h < 8), irq_rx_r);
        rdc("rx full", `CAF_ADDR_RXFLG, 32'h1, 32'(h < 8));
        if (h < 8) begin
          rdc("hit", `CAF_ADDR_FCTRL, 32'h37,
              32'(m * 16 + h));
          wr(`CAF_ADDR_RXFLG, 32'h1);
        end
      end
    end
    wr(`CAF_ADDR_FCTRL, 32'h20);
    wr(8'h7C, 32'hFF);
    repeat (3) i_node.send($urandom, 2, 1'b1);
    repeat (6) @(posedge ref_clk);
    rdc("overrun", `CAF_ADDR_RXFLG, 32'h3, 32'h3);
    chk("err irq", 32'h1, irq_error_r);
    wr(`CAF_ADDR_RXFLG, 32'h1);
    repeat (3) @(posedge ref_clk);
    rdc("refill", `CAF_ADDR_RXFLG, 32'h3, 32'h3);
    wr(`CAF_ADDR_RXFLG, 32'h3);
    wr(`CAF_ADDR_CTRL1, 32'hA5);
    wr(`CAF_ADDR_BTIME1, 32'h3C);
    wr(`CAF_ADDR_CTRL0, 32'h0);
    wr(`CAF_ADDR_FCTRL, 32'h30);
    wr(`CAF_ADDR_BTIME0, 32'h5A);
    wr(8'h40, {24'h0, ~pat[0]});
    rdc("mode", `CAF_ADDR_FCTRL, 32'h30, 32'h20);
    rdc("timing", `CAF_ADDR_BTIME0, 32'hFF, 32'h0);
    rdc("pattern", 8'h40, 32'hFF, {24'h0, pat[0]});
    chk("ctrl1 out", 32'hA5, module_ctrl1_r);
    chk("timing1 out", 32'h3C, bit_timing1_r);
    chk("timing0 out", 32'h0, bit_timing0_r);
    wr(`CAF_ADDR_ERRCNT, 32'hFFFFFFFF);
    for (i = 0; i < 6; i = i + 1) begin
      tx_err_cnt <= 9'(ev[i]);
      rx_err_cnt <= 9'(ev[5 - i]);
      repeat (3) @(posedge ref_clk);
      h = (ev[5 - i] > 95) * 64 + (ev[i] > 95) * 32 + (ev[5 - i] > 127) * 16;
      h = h + (ev[i] > 127) * 8 + (ev[i] > 255) * 4;
      chk("err irq", 32'(h != 0), irq_error_r);
      rdc("err flags", `CAF_ADDR_RXFLG, 32'hFC, 32'(h));
      wr(`CAF_ADDR_RXFLG, 32'hFC);
      rdc("held flags", `CAF_ADDR_RXFLG, 32'hFC, 32'(h));
      rdc("counters", `CAF_ADDR_ERRCNT, 32'h01FF01FF,
          {7'h0, tx_err_cnt, 7'h0, rx_err_cnt});
      rx_err_cnt <= 9'h0;
      tx_err_cnt <= 9'h0;
      wr(`CAF_ADDR_RXFLG, 32'hFC);
      rdc("cleared", `CAF_ADDR_RXFLG, 32'hFC, 32'h0);
    end
    wr(`CAF_ADDR_TXIEN, 32'h7);
    repeat (2) @(posedge ref_clk);
    chk("tx irq", 32'h1, irq_tx_r);
    for (i = 0; i < 3; i = i + 1) wr(`CAF_ADDR_TXFLG, 32'h1 << i);
    repeat (2) @(posedge ref_clk);
    chk("tx irq", 32'h0, irq_tx_r);
    tx_buf_done <= 3'h2;
    @(posedge ref_clk);
    tx_buf_done <= 3'h0;
    repeat (3) @(posedge ref_clk);
    chk("tx irq", 32'h1, irq_tx_r);
    wr(`CAF_ADDR_TXFLG, 32'h0);
    rdc("tx flags", `CAF_ADDR_TXFLG, 32'h7, 32'h2);
    wr(`CAF_ADDR_RXIEN, 32'hFF);
    sleep_ack <= 1'b1;
    i_node.send(32'h0, 4, 1'b0);
    repeat (6) @(posedge ref_clk);
    chk("wake irq", 32'h1, irq_wakeup_r);
    chk("tx pin", 32'h1, can_tx_pin_r);
    sleep_ack <= 1'b0;
    power_down <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk("wake irq", 32'h0, irq_wakeup_r);
    power_down <= 1'b0;
    rdc("wake flag", `CAF_ADDR_RXFLG, 32'h80, 32'h80);
    wr(`CAF_ADDR_RXFLG, 32'h80);
    rdc("wake flag", `CAF_ADDR_RXFLG, 32'h80, 32'h0);
    wr(`CAF_ADDR_CTRL0, 32'h2);
    rdc("ctrl0", `CAF_ADDR_CTRL0, 32'h3, 32'h2);
    chk("sleep req", 32'h1, sleep_req_r);
    conclude;
  end
endmodule // can_accept_filter_irq_tb
